/* logic/sbwm_regs.svh */
// Constants for the per-beat lane-masked write path
//
// Summary of operation
// - Write starts on load low with write select low; beats follow on two next edges.
// - Lane selects are sampled with each beat and apply to that beat only.
// - Lane selects may differ between the two beats; each beat keeps its own mask.
// - 8-bit width, both half selects low: write all eight bits.
// - 8-bit width, select 0 low only: write bits 3..0, keep bits 7..4.
// - 8-bit width, select 1 low only: write bits 7..4, keep bits 3..0.
// - 18-bit width, both selects low: write all eighteen bits.
// - 18-bit width, select 0 low only: write bits 8..0, keep bits 17..9.
// - 18-bit width, select 1 low only: write bits 17..9, keep bits 8..0.
// - 8-bit and 18-bit widths, both selects high: word left unchanged.
// - 9-bit width, one select: low writes bits 8..0, high changes nothing.
// - 36-bit width, all four selects low: write all thirty-six bits.
// - 36-bit width, only select 0 low: write bits 8..0, keep the rest.
// - 36-bit width, only select 1, 2 or 3 low: write that lane only.
// - 36-bit width, all selects high: word left unchanged.
`ifndef SBWM_REGS_SVH
`define SBWM_REGS_SVH
`define SBWM_NIBBLE_W 4
`define SBWM_LANE_W 9
`define SBWM_DW_X8 8
`define SBWM_DW_X9 9
`define SBWM_DW_X18 18
`define SBWM_DW_X36 36
`define SBWM_DEF_AW 4
`endif

/* logic/sbwm_pkg.sv */
// Types for the per-beat lane-masked write path
package sbwm_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BEAT0,
    ST_BEAT1
  } sbwm_state_t;

  // Per-beat select pins, all active low
  typedef struct packed {
    logic lane_select_3_n;
    logic lane_select_2_n;
    logic lane_select_1_n;
    logic lane_select_0_n;
    logic half_select_1_n;
    logic half_select_0_n;
  } sbwm_sel_t;

  // Command pins sampled at the address edge
  typedef struct packed {
    logic load_request_n;
    logic read_write_n;
  } sbwm_cmd_t;
endpackage : sbwm_pkg

/* logic/sbwm_write_mask.sv */
// Burst write path of the SRAM core with per-beat lane masking
`timescale 1ns/1ps
`default_nettype none
`include "sbwm_regs.svh"
module sbwm_write_mask #(
  parameter int DW = `SBWM_DW_X18,
  parameter int AW = `SBWM_DEF_AW
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Command and address
  input wire sbwm_pkg::sbwm_cmd_t cmd,
  input wire logic [AW-1:0] wr_addr,
  // Data beat and its selects
  input wire logic [DW-1:0] wr_data,
  input wire sbwm_pkg::sbwm_sel_t sel,
  // Array read-back
  input wire logic [AW-1:0] rd_addr,
  output logic [2*DW-1:0] rd_data,
  // Status
  output logic write_commit,
  output logic busy
);
  import sbwm_pkg::*;

  localparam int DEPTH = 1 << AW;

  // Expand one beat's active-low selects into a bit write mask
  function automatic logic [DW-1:0] beat_mask(input sbwm_sel_t s);
    logic [35:0] m;
    m = 36'h0;
    if (DW == `SBWM_DW_X8) begin
      m[`SBWM_NIBBLE_W-1:0] = {`SBWM_NIBBLE_W{~s.half_select_0_n}};
      m[2*`SBWM_NIBBLE_W-1:`SBWM_NIBBLE_W] = {`SBWM_NIBBLE_W{~s.half_select_1_n}};
    end else begin
      m[`SBWM_LANE_W-1:0] = {`SBWM_LANE_W{~s.lane_select_0_n}};
      if (DW >= `SBWM_DW_X18) begin
        m[2*`SBWM_LANE_W-1:`SBWM_LANE_W] = {`SBWM_LANE_W{~s.lane_select_1_n}};
      end
      if (DW == `SBWM_DW_X36) begin
        m[3*`SBWM_LANE_W-1:2*`SBWM_LANE_W] = {`SBWM_LANE_W{~s.lane_select_2_n}};
        m[4*`SBWM_LANE_W-1:3*`SBWM_LANE_W] = {`SBWM_LANE_W{~s.lane_select_3_n}};
      end
    end
    return m[DW-1:0];
  endfunction : beat_mask

  sbwm_state_t state_r, state_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [DW-1:0] b0_data_r, b0_data_nxt;
  logic [DW-1:0] b0_mask_r, b0_mask_nxt;
  logic post_vld_r, post_vld_nxt;
  logic [AW-1:0] post_addr_r, post_addr_nxt;
  logic [2*DW-1:0] post_data_r, post_data_nxt;
  logic [2*DW-1:0] post_mask_r, post_mask_nxt;
  logic [2*DW-1:0] mem_r [DEPTH];
  logic [2*DW-1:0] mem_nxt [DEPTH];
  logic [2*DW-1:0] rd_data_r, rd_data_nxt;
  logic start;

  // A new write may be taken while the second beat of the last one lands
  assign start = (state_r == ST_IDLE || state_r == ST_BEAT1)
                 && !cmd.load_request_n && !cmd.read_write_n;

  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    b0_data_nxt = b0_data_r;
    b0_mask_nxt = b0_mask_r;
    post_vld_nxt = 1'b0;
    post_addr_nxt = post_addr_r;
    post_data_nxt = post_data_r;
    post_mask_nxt = post_mask_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_BEAT0;
          addr_nxt = wr_addr;
        end
      end
      ST_BEAT0: begin
        // First beat and its own mask
        b0_data_nxt = wr_data;
        b0_mask_nxt = beat_mask(sel);
        state_nxt = ST_BEAT1;
      end
      ST_BEAT1: begin
        // Second beat sampled with fresh selects; both masks posted with data
        post_vld_nxt = 1'b1;
        post_addr_nxt = addr_r;
        post_data_nxt = {wr_data, b0_data_r};
        post_mask_nxt = {beat_mask(sel), b0_mask_r};
        if (start) begin
          state_nxt = ST_BEAT0;
          addr_nxt = wr_addr;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  // Array update, one slice per word: unselected bits keep their old contents
  for (genvar w = 0; w < DEPTH; w++) begin : g_word
    logic hit;

    // Only the posted word is touched; every other word holds
    assign hit = post_vld_r && (post_addr_r == AW'(w));

    always_comb begin
      mem_nxt[w] = mem_r[w];
      if (hit) begin
        mem_nxt[w] = (mem_r[w] & ~post_mask_r) | (post_data_r & post_mask_r);
      end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        mem_r[w] <= '0;
      end else begin
        mem_r[w] <= mem_nxt[w];
      end
    end
  end

  // Read-back port; no bypass, so a word reads new one edge after it lands in the array
  always_comb begin
    rd_data_nxt = mem_r[rd_addr];
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // Burst control
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      addr_r <= '0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
    end
  end

  // First beat held until its partner arrives
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      b0_data_r <= '0;
      b0_mask_r <= '0;
    end else begin
      b0_data_r <= b0_data_nxt;
      b0_mask_r <= b0_mask_nxt;
    end
  end

  // Posted write: masks travel with their data so late commits stay correct
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      post_vld_r <= 1'b0;
      post_addr_r <= '0;
      post_data_r <= '0;
      post_mask_r <= '0;
    end else begin
      post_vld_r <= post_vld_nxt;
      post_addr_r <= post_addr_nxt;
      post_data_r <= post_data_nxt;
      post_mask_r <= post_mask_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign write_commit = post_vld_r;
  assign busy = (state_r != ST_IDLE) || post_vld_r;
endmodule : sbwm_write_mask
`default_nettype wire

/* bench/sbwm_chk.sv */
// Timing and lane-mask checks
`timescale 1ns/1ps
`default_nettype none
module sbwm_chk import sbwm_pkg::*; #(parameter int DW = 18, parameter int AW = 4) (
  input wire logic core_clk, arst_n, write_commit, busy,
  input wire sbwm_cmd_t cmd,
  input wire sbwm_sel_t sel,
  input wire logic [AW-1:0] wr_addr, rd_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [2*DW-1:0] rd_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire logic req = !busy && cmd == '0 && rd_addr == wr_addr;
  // Held lanes read back their old value
  property p_b0(s, int lo);
    logic [8:0] v;
    (req ##1 (1, v = s ? rd_data[lo+:9] : wr_data[lo+:9])) |-> ##4 rd_data[lo+:9] == v;
  endproperty
  property p_b1(s, int lo);
    logic [8:0] v;
    (req ##2 (1, v = s ? rd_data[DW+lo+:9] : wr_data[lo+:9])) |-> ##3 rd_data[DW+lo+:9] == v;
  endproperty
  a_b0_lane0: assert property (p_b0(sel.lane_select_0_n, 0)) else $error("b0 l0");
  a_b0_lane1: assert property (p_b0(sel.lane_select_1_n, 9)) else $error("b0 l1");
  a_b1_lane0: assert property (p_b1(sel.lane_select_0_n, 0)) else $error("b1 l0");
  a_b1_lane1: assert property (p_b1(sel.lane_select_1_n, 9)) else $error("b1 l1");
  a_commit_time: assert property (req |-> ##3 write_commit) else $error("commit late");
  a_commit_src: assert property (write_commit |-> $past(cmd, 3) == '0) else $error("stray commit");
  a_commit_pulse: assert property (write_commit |=> !write_commit) else $error("long commit");
  a_busy_req: assert property (req |=> busy [*3]) else $error("not busy");
  c_req: cover property (req);
  c_held: cover property (req ##1 sel.lane_select_0_n);
  c_commit: cover property (write_commit);
endmodule : sbwm_chk
bind sbwm_write_mask sbwm_chk #(.DW(DW), .AW(AW)) u_chk (.*);
`default_nettype wire

/* bench/sbwm_ctl.sv */
// Controller model driving write bursts
`timescale 1ns/1ps
`default_nettype none
module sbwm_ctl import sbwm_pkg::*; (
  input wire logic core_clk,
  output var sbwm_cmd_t cmd,
  output var logic [3:0] wr_addr,
  output var logic [17:0] wr_data,
  output var sbwm_sel_t sel
);
  initial begin
    cmd = '1;
    wr_addr = '0;
    wr_data = '0;
    sel = '1;
  end
  task automatic wr(input logic [3:0] a, input logic [17:0] d0, d1, input sbwm_sel_t s0, s1);
    @(posedge core_clk) begin cmd <= '0; wr_addr <= a; end
    @(posedge core_clk) begin cmd <= '1; wr_data <= d0; sel <= s0; end
    @(posedge core_clk) begin wr_data <= d1; sel <= s1; end
    // Released lines flip so stale values never look valid
    @(posedge core_clk) begin wr_data <= ~d1; sel <= ~s1; wr_addr <= ~a; end
  endtask : wr
endmodule : sbwm_ctl
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the lane-masked write path
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sbwm_pkg::*;
  logic core_clk = 1'b0, arst_n = 1'b0, write_commit, busy;
  logic [3:0] rd_addr = '0, wr_addr;
  logic [35:0] rd_data, mem [16], q [$];
  logic [17:0] wr_data;
  logic [71:0] rd_data_w, mem_w [16], q_w [$];
  sbwm_cmd_t cmd;
  sbwm_sel_t sel;
  int error_cnt = 0, tests_run = 0, seed = 32'h5752a9a6;
  initial forever #12.5 core_clk = ~core_clk;
  sbwm_write_mask u_dut (.*);
  sbwm_ctl u_ctl (.*);
  // Wide variant shares the burst stimulus to reach all four lanes
  sbwm_write_mask #(.DW(36), .AW(4)) u_dut_w (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .cmd(cmd),
    .wr_addr(wr_addr),
    .wr_data({wr_data, wr_data}),
    .sel(sel),
    .rd_addr(rd_addr),
    .rd_data(rd_data_w),
    .write_commit(),
    .busy()
  );
  task automatic check(input logic [71:0] got, want);
    tests_run++;
    if (got !== want) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : check
  task automatic test_done;
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  function automatic logic [17:0] mix(logic [17:0] o, d, sbwm_sel_t s);
    logic [17:0] m;
    m = {{9{~s.lane_select_1_n}}, {9{~s.lane_select_0_n}}};
    return (o & ~m) | (d & m);
  endfunction : mix
  function automatic logic [35:0] mix_w(logic [35:0] o, d, sbwm_sel_t s);
    logic [35:0] m;
    m = {{9{~s.lane_select_3_n}}, {9{~s.lane_select_2_n}}, {9{~s.lane_select_1_n}}, {9{~s.lane_select_0_n}}};
    return (o & ~m) | (d & m);
  endfunction : mix_w
  always @(posedge core_clk) if (write_commit === 1'b1) begin
    repeat (2) @(posedge core_clk);
    check(rd_data, q.pop_front());
    check(rd_data_w, q_w.pop_front());
  end
  initial begin
    #20000;
    error_cnt++;
    test_done();
  end
  initial begin
    logic [3:0] a;
    logic [17:0] d0, d1;
    sbwm_sel_t s0, s1;
    for (int i = 0; i < 16; i++) mem[i] = '0;
    for (int i = 0; i < 16; i++) mem_w[i] = '0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    // Both beats walk all four lane mixes
    for (int i = 0; i < 32; i++) begin
      a = $random(seed);
      d0 = $random(seed);
      d1 = $random(seed);
      s0 = $random(seed);
      s1 = $random(seed);
      s0[3:2] = i[1:0];
      s1[3:2] = i[3:2];
      mem[a] = {mix(mem[a][35:18], d1, s1), mix(mem[a][17:0], d0, s0)};
      q.push_back(mem[a]);
      mem_w[a] = {mix_w(mem_w[a][71:36], {d1, d1}, s1), mix_w(mem_w[a][35:0], {d0, d0}, s0)};
      q_w.push_back(mem_w[a]);
      rd_addr <= a;
      u_ctl.wr(a, d0, d1, s0, s1);
      repeat (4) @(posedge core_clk);
    end
    test_done();
  end
endmodule : tb_top
`default_nettype wire
